// ===== logic/fsl_regs.svh
`ifndef FSL_REGS_SVH
`define FSL_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// clock and pattern timing
`define FSL_CLK_HZ            50000000
`define FSL_UNIT_MS           200
`define FSL_SINGLE_OFF_MS     1000
`define FSL_DOUBLE_OFF_MS     1000
`define FSL_LDR_IDLE_HZ       1
`define FSL_LDR_BUSY_HZ       6
`define FSL_FLICKER_MS        50
`define FSL_UNIT_CYC          ((`FSL_CLK_HZ / 1000) * `FSL_UNIT_MS)
`define FSL_LDR_IDLE_CYC      (`FSL_CLK_HZ / (2 * `FSL_LDR_IDLE_HZ))
`define FSL_LDR_BUSY_CYC      (`FSL_CLK_HZ / (2 * `FSL_LDR_BUSY_HZ))
`define FSL_FLICKER_CYC       ((`FSL_CLK_HZ / 1000) * `FSL_FLICKER_MS)
`define FSL_SINGLE_PHASES     (1 + (`FSL_SINGLE_OFF_MS / `FSL_UNIT_MS))
`define FSL_DOUBLE_PHASES     (3 + (`FSL_DOUBLE_OFF_MS / `FSL_UNIT_MS))

////////////////////////////////////////////////////////////////////////////////
// register offsets (byte addresses)
`define FSL_ADDR_LAMP         8'h00
`define FSL_ADDR_IRQ_STAT     8'h04
`define FSL_ADDR_IRQ_MASK     8'h08

////////////////////////////////////////////////////////////////////////////////
// lamp status fields
`define FSL_LAMP_OUT_GRN      0
`define FSL_LAMP_IN_GRN       1
`define FSL_LAMP_NET_GRN      2
`define FSL_LAMP_NET_RED      3
`define FSL_LAMP_ERR_RED      4
`define FSL_LAMP_AL_LSB       8
`define FSL_LAMP_LDR_RUN      12
`define FSL_LAMP_LDR_BUSY     13

////////////////////////////////////////////////////////////////////////////////
// interrupt status and mask fields
`define FSL_IRQ_W             6
`define FSL_IRQ_LINK          0
`define FSL_IRQ_AL            1
`define FSL_IRQ_CFG           2
`define FSL_IRQ_WDOG          3
`define FSL_IRQ_FATAL         4
`define FSL_IRQ_LDR           5
`define FSL_IRQ_MASK_RST      6'h00

`endif

// ===== logic/fsl_pkg.sv
`default_nettype none

package fsl_pkg;

  // slave communication state as reported by the controller
  typedef enum logic [1:0] {
    FSL_AL_INIT,
    FSL_AL_PREOP,
    FSL_AL_SAFEOP,
    FSL_AL_OP
  } fsl_al_e;

  // error lamp pattern, most severe last
  typedef enum logic [2:0] {
    FSL_ERR_OFF,
    FSL_ERR_BLINK,
    FSL_ERR_SINGLE,
    FSL_ERR_DOUBLE,
    FSL_ERR_STEADY,
    FSL_ERR_LOADER
  } fsl_err_e;

endpackage : fsl_pkg

`default_nettype wire

// ===== logic/fsl_toggle.sv
`timescale 1ns/1ns
`default_nettype none

module fsl_toggle #(
  parameter int unsigned HALF_CYC = 10
) (
  input  wire logic clk,
  input  wire logic srst,
  output logic      tick,
  output logic      level
);

  localparam int unsigned CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

  generate
    if (HALF_CYC < 1) begin : g_bad_half
      $error("fsl_toggle: HALF_CYC must be at least one");
    end
  endgenerate

  logic [CW-1:0] cnt_ff;
  logic          tick_ff;
  logic          level_ff;
  wire logic     wrap;

  assign wrap  = (cnt_ff == CW'(HALF_CYC - 1));
  assign tick  = tick_ff;
  assign level = level_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff   <= '0;
      tick_ff  <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      cnt_ff   <= wrap ? '0 : cnt_ff + CW'(1);
      tick_ff  <= wrap;
      level_ff <= level_ff ^ wrap;
    end
  end

endmodule : fsl_toggle

`default_nettype wire

// ===== logic/fsl_led_driver.sv
`timescale 1ns/1ns
`default_nettype none
`include "fsl_regs.svh"

// Operation
// [R1] four lamps: outgoing and incoming link/activity, network state, error
// [R2] link lamp dark without physical link or before the controller started
// [R3] link lamp steady green with link but no frame traffic
// [R4] link lamp flickers green while frames pass on its port
// [R5] network lamp dark in Init
// [R6] network lamp blinks green in Pre-Operational
// [R7] network lamp single-flashes green in Safe-Operational
// [R8] network lamp steady green in Operational
// [R9] network lamp red only while the firmware loader runs
// [R10] loader idle: network and error lamps blink at 1 Hz
// [R11] loader processing commands: network and error lamps blink at 6 Hz
// [R12] error lamp dark when no error is present
// [R13] error lamp red for any error; configuration error blinks
// [R14] error lamp single flash when the state change field equals 01 hex
// [R15] error lamp double flash after a sync manager watchdog timeout
// [R16] error lamp steady on interface failure or fatal stall
// [R17] blink 200 ms toggle; flashes 200 ms pulses, 1000 ms off
// [R18] error lamp shows the most severe active pattern
module fsl_led_driver #(
  parameter int unsigned UNIT_CYC     = `FSL_UNIT_CYC,
  parameter int unsigned LDR_IDLE_CYC = `FSL_LDR_IDLE_CYC,
  parameter int unsigned LDR_BUSY_CYC = `FSL_LDR_BUSY_CYC,
  parameter int unsigned FLICKER_CYC  = `FSL_FLICKER_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  // bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // detectors and sources
  input  wire logic        ctrl_started,
  input  wire logic        link_out,
  input  wire logic        link_in,
  input  wire logic        frame_out,
  input  wire logic        frame_in,
  input  wire logic [1:0]  al_state,
  input  wire logic [7:0]  al_change,
  input  wire logic        cfg_error,
  input  wire logic        sm_wdog_timeout,
  input  wire logic        pdi_fail,
  input  wire logic        fatal_stall,
  input  wire logic        firmware_loader_protocol_run,
  input  wire logic        firmware_loader_protocol_busy,
  // lamps and interrupt
  output logic             lamp_out_green,
  output logic             lamp_in_green,
  output logic             lamp_net_green,
  output logic             lamp_net_red,
  output logic             lamp_err_red,
  output logic             irq
);

  generate
    if (UNIT_CYC < 1 || LDR_IDLE_CYC < 1 || LDR_BUSY_CYC < 1 || FLICKER_CYC < 1)
    begin : g_bad_timing
      $error("fsl_led_driver: every timing count must be at least one");
    end
  endgenerate

  localparam int unsigned SPH = `FSL_SINGLE_PHASES;
  localparam int unsigned DPH = `FSL_DOUBLE_PHASES;

  ////////////////////////////////////////////////////////////////////////////
  // time bases
  wire logic unit_tick;
  wire logic unit_lvl;
  wire logic idle_lvl;
  wire logic busy_lvl;
  wire logic flick_tick;
  wire logic flick_lvl;

  // 200 ms blink base, also paces the flash phases
  fsl_toggle #(.HALF_CYC(UNIT_CYC)) u_unit (  // see [R17]
    .clk   (clk),
    .srst  (srst),
    .tick  (unit_tick),
    .level (unit_lvl)
  );

  fsl_toggle #(.HALF_CYC(LDR_IDLE_CYC)) u_ldr_idle (  // see [R10]
    .clk   (clk),
    .srst  (srst),
    .tick  (),
    .level (idle_lvl)
  );

  fsl_toggle #(.HALF_CYC(LDR_BUSY_CYC)) u_ldr_busy (  // see [R11]
    .clk   (clk),
    .srst  (srst),
    .tick  (),
    .level (busy_lvl)
  );

  fsl_toggle #(.HALF_CYC(FLICKER_CYC)) u_flick (
    .clk   (clk),
    .srst  (srst),
    .tick  (flick_tick),
    .level (flick_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // flash phase counters
  logic [3:0] sph_ff;
  logic [3:0] dph_ff;
  wire logic  single_on;
  wire logic  double_on;

  always_ff @(posedge clk) begin
    if (srst) begin
      sph_ff <= 4'h0;
      dph_ff <= 4'h0;
    end else if (unit_tick) begin
      sph_ff <= (sph_ff == 4'(SPH - 1)) ? 4'h0 : sph_ff + 4'h1;
      dph_ff <= (dph_ff == 4'(DPH - 1)) ? 4'h0 : dph_ff + 4'h1;
    end
  end

  // one 200 ms pulse, then the off stretch
  assign single_on = (sph_ff == 4'h0);  // see [R17]
  // two 200 ms pulses 200 ms apart, then the off stretch
  assign double_on = (dph_ff == 4'h0) || (dph_ff == 4'h2);  // see [R17]

  ////////////////////////////////////////////////////////////////////////////
  // frame activity stretch, so short frames still give visible flicker
  logic act_out_seen_ff;
  logic act_in_seen_ff;
  logic act_out_ff;
  logic act_in_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      act_out_seen_ff <= 1'b0;
      act_in_seen_ff  <= 1'b0;
      act_out_ff      <= 1'b0;
      act_in_ff       <= 1'b0;
    end else if (flick_tick) begin
      act_out_ff      <= act_out_seen_ff | frame_out;
      act_in_ff       <= act_in_seen_ff | frame_in;
      act_out_seen_ff <= 1'b0;
      act_in_seen_ff  <= 1'b0;
    end else begin
      act_out_seen_ff <= act_out_seen_ff | frame_out;
      act_in_seen_ff  <= act_in_seen_ff | frame_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lamp selection
  wire logic             up_out;
  wire logic             up_in;
  wire logic             nxt_out_grn;
  wire logic             nxt_in_grn;
  wire logic             ldr_run;
  wire logic             ldr_lvl;
  wire logic             al_applied;
  fsl_pkg::fsl_al_e      al_cur;
  fsl_pkg::fsl_err_e     err_sel;
  logic                  nxt_net_grn;
  logic                  nxt_err_red;
  wire logic             nxt_net_red;

  assign up_out = ctrl_started & link_out;  // see [R2]
  assign up_in  = ctrl_started & link_in;  // see [R2]
  // steady with link, flicker during traffic
  assign nxt_out_grn = up_out & (act_out_ff ? flick_lvl : 1'b1);  // see [R3] [R4]
  assign nxt_in_grn  = up_in & (act_in_ff ? flick_lvl : 1'b1);  // see [R3] [R4]

  assign ldr_run = firmware_loader_protocol_run;
  // busy loader blinks fast, idle loader slow
  assign ldr_lvl = firmware_loader_protocol_busy ? busy_lvl : idle_lvl;  // see [R10] [R11]

  assign al_cur     = fsl_pkg::fsl_al_e'(al_state);
  assign al_applied = (al_change == 8'h01);  // see [R14]

  always_comb begin
    case (al_cur)
      fsl_pkg::FSL_AL_INIT:   nxt_net_grn = 1'b0;  // see [R5]
      fsl_pkg::FSL_AL_PREOP:  nxt_net_grn = unit_lvl;  // see [R6]
      fsl_pkg::FSL_AL_SAFEOP: nxt_net_grn = single_on;  // see [R7]
      fsl_pkg::FSL_AL_OP:     nxt_net_grn = 1'b1;  // see [R8]
      default:                nxt_net_grn = 1'b0;
    endcase
    if (ldr_run) begin
      nxt_net_grn = 1'b0;
    end
  end

  // red network colour is reserved for the loader
  assign nxt_net_red = ldr_run & ldr_lvl;  // see [R9] [R10] [R11]

  // severity order
  always_comb begin
    if (ldr_run) begin
      err_sel = fsl_pkg::FSL_ERR_LOADER;
    end else if (pdi_fail || fatal_stall) begin
      err_sel = fsl_pkg::FSL_ERR_STEADY;  // see [R16] [R18]
    end else if (sm_wdog_timeout) begin
      err_sel = fsl_pkg::FSL_ERR_DOUBLE;  // see [R15] [R18]
    end else if (al_applied) begin
      err_sel = fsl_pkg::FSL_ERR_SINGLE;  // see [R14] [R18]
    end else if (cfg_error) begin
      err_sel = fsl_pkg::FSL_ERR_BLINK;  // see [R13] [R18]
    end else begin
      err_sel = fsl_pkg::FSL_ERR_OFF;  // see [R12]
    end
  end

  always_comb begin
    case (err_sel)
      fsl_pkg::FSL_ERR_OFF:    nxt_err_red = 1'b0;  // see [R12]
      fsl_pkg::FSL_ERR_BLINK:  nxt_err_red = unit_lvl;  // see [R13]
      fsl_pkg::FSL_ERR_SINGLE: nxt_err_red = single_on;  // see [R14]
      fsl_pkg::FSL_ERR_DOUBLE: nxt_err_red = double_on;  // see [R15]
      fsl_pkg::FSL_ERR_STEADY: nxt_err_red = 1'b1;  // see [R16]
      fsl_pkg::FSL_ERR_LOADER: nxt_err_red = ldr_lvl;  // see [R10] [R11]
      default:                 nxt_err_red = 1'b0;
    endcase
  end

  logic lamp_out_ff;
  logic lamp_in_ff;
  logic net_grn_ff;
  logic net_red_ff;
  logic err_red_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      lamp_out_ff <= 1'b0;
      lamp_in_ff  <= 1'b0;
      net_grn_ff  <= 1'b0;
      net_red_ff  <= 1'b0;
      err_red_ff  <= 1'b0;
    end else begin
      lamp_out_ff <= nxt_out_grn;
      lamp_in_ff  <= nxt_in_grn;
      net_grn_ff  <= nxt_net_grn;
      net_red_ff  <= nxt_net_red;
      err_red_ff  <= nxt_err_red;
    end
  end

  // four lamps, network lamp bicolour
  assign lamp_out_green = lamp_out_ff;  // see [R1]
  assign lamp_in_green  = lamp_in_ff;  // see [R1]
  assign lamp_net_green = net_grn_ff;  // see [R1]
  assign lamp_net_red   = net_red_ff;  // see [R1]
  assign lamp_err_red   = err_red_ff;  // see [R1]

  ////////////////////////////////////////////////////////////////////////////
  // event detection
  logic [1:0]           link_d_ff;
  logic [1:0]           al_d_ff;
  logic                 cfg_d_ff;
  logic                 wdog_d_ff;
  logic                 fatal_d_ff;
  logic                 ldr_d_ff;
  wire logic [`FSL_IRQ_W-1:0] evt;

  always_ff @(posedge clk) begin
    if (srst) begin
      link_d_ff  <= 2'h0;
      al_d_ff    <= 2'h0;
      cfg_d_ff   <= 1'b0;
      wdog_d_ff  <= 1'b0;
      fatal_d_ff <= 1'b0;
      ldr_d_ff   <= 1'b0;
    end else begin
      link_d_ff  <= {up_in, up_out};
      al_d_ff    <= al_state;
      cfg_d_ff   <= cfg_error;
      wdog_d_ff  <= sm_wdog_timeout;
      fatal_d_ff <= pdi_fail | fatal_stall;
      ldr_d_ff   <= ldr_run;
    end
  end

  assign evt[`FSL_IRQ_LINK]  = (link_d_ff != {up_in, up_out});
  assign evt[`FSL_IRQ_AL]    = (al_d_ff != al_state);
  assign evt[`FSL_IRQ_CFG]   = cfg_error & ~cfg_d_ff;
  assign evt[`FSL_IRQ_WDOG]  = sm_wdog_timeout & ~wdog_d_ff;
  assign evt[`FSL_IRQ_FATAL] = (pdi_fail | fatal_stall) & ~fatal_d_ff;
  assign evt[`FSL_IRQ_LDR]   = ldr_run & ~ldr_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, always OKAY
  logic                 dph_wr_ff;
  logic [7:0]           dph_addr_ff;
  logic [31:0]          rdata_ff;
  logic [`FSL_IRQ_W-1:0] irq_stat_ff;
  logic [`FSL_IRQ_W-1:0] irq_mask_ff;
  logic [31:0]          lamp_word;
  wire logic            ap_take;
  wire logic            ap_rd;
  wire logic            ap_wr;
  wire logic            in_range;
  wire logic            sel_lamp;
  wire logic            sel_stat;
  wire logic            sel_mask;
  wire logic            wr_mask;
  wire logic            rd_clr;
  wire logic [31:0]     nxt_rdata;
  wire logic [`FSL_IRQ_W-1:0] nxt_irq_stat;

  assign ap_take  = hsel & hready & htrans[1];
  assign ap_rd    = ap_take & ~hwrite;
  assign ap_wr    = ap_take & hwrite & (hsize == 3'h2);
  assign in_range = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);
  assign sel_lamp = in_range & (haddr[7:0] == `FSL_ADDR_LAMP);
  assign sel_stat = in_range & (haddr[7:0] == `FSL_ADDR_IRQ_STAT);
  assign sel_mask = in_range & (haddr[7:0] == `FSL_ADDR_IRQ_MASK);

  always_comb begin
    lamp_word = 32'h0000_0000;
    lamp_word[`FSL_LAMP_OUT_GRN] = lamp_out_ff;
    lamp_word[`FSL_LAMP_IN_GRN]  = lamp_in_ff;
    lamp_word[`FSL_LAMP_NET_GRN] = net_grn_ff;
    lamp_word[`FSL_LAMP_NET_RED] = net_red_ff;
    lamp_word[`FSL_LAMP_ERR_RED] = err_red_ff;
    lamp_word[`FSL_LAMP_AL_LSB +: 2] = al_state;
    lamp_word[`FSL_LAMP_LDR_RUN]  = ldr_run;
    lamp_word[`FSL_LAMP_LDR_BUSY] = firmware_loader_protocol_busy;
  end

  // unmapped reads return zero
  assign nxt_rdata = sel_lamp ? lamp_word :
                     sel_stat ? {{(32-`FSL_IRQ_W){1'b0}}, irq_stat_ff} :
                     sel_mask ? {{(32-`FSL_IRQ_W){1'b0}}, irq_mask_ff} :
                     32'h0000_0000;

  // read clears, but a new event in the same cycle survives
  assign rd_clr       = ap_rd & sel_stat;
  assign nxt_irq_stat = (rd_clr ? {`FSL_IRQ_W{1'b0}} : irq_stat_ff) | evt;
  assign wr_mask      = dph_wr_ff & (dph_addr_ff == `FSL_ADDR_IRQ_MASK);

  always_ff @(posedge clk) begin
    if (srst) begin
      dph_wr_ff   <= 1'b0;
      dph_addr_ff <= 8'h00;
      rdata_ff    <= 32'h0000_0000;
    end else begin
      dph_wr_ff   <= ap_wr & in_range;
      dph_addr_ff <= haddr[7:0];
      rdata_ff    <= ap_rd ? nxt_rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat_ff <= {`FSL_IRQ_W{1'b0}};
      irq_mask_ff <= `FSL_IRQ_MASK_RST;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= wr_mask ? hwdata[`FSL_IRQ_W-1:0] : irq_mask_ff;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;
  assign irq       = |(irq_stat_ff & irq_mask_ff);

endmodule : fsl_led_driver

`default_nettype wire

// ===== verification/fsl_lamp_mon.sv
`timescale 1ns/1ns
`default_nettype none

// operator view of the panel: lit cycles and changes per lamp while enabled
module fsl_lamp_mon (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic [4:0] lamps,
  output logic [7:0]      ons [5],
  output logic [7:0]      edges [5]
);
  logic [4:0] prev_ff;

  always_ff @(posedge clk) begin
    prev_ff <= lamps;
    for (int i = 0; i < 5; i++) begin
      if (clr) begin
        ons[i]   <= 8'h00;
        edges[i] <= 8'h00;
      end else if (en) begin
        ons[i]   <= ons[i] + 8'(lamps[i]);
        edges[i] <= edges[i] + 8'(lamps[i] != prev_ff[i]);
      end
    end
  end
endmodule : fsl_lamp_mon

`default_nettype wire

// ===== verification/fsl_led_driver_sva.sv
`timescale 1ns/1ns
`default_nettype none

module fsl_led_driver_sva (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic        ctrl_started,
  input wire logic        link_out,
  input wire logic        link_in,
  input wire logic        frame_out,
  input wire logic [1:0]  al_state,
  input wire logic [7:0]  al_change,
  input wire logic        cfg_error,
  input wire logic        sm_wdog_timeout,
  input wire logic        pdi_fail,
  input wire logic        fatal_stall,
  input wire logic        firmware_loader_protocol_run,
  input wire logic        lamp_out_green,
  input wire logic        lamp_in_green,
  input wire logic        lamp_net_green,
  input wire logic        lamp_net_red,
  input wire logic        lamp_err_red
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  wire logic ldr = firmware_loader_protocol_run;
  wire logic no_err = !cfg_error && !sm_wdog_timeout && !pdi_fail && !fatal_stall;

  AST_OUT_DARK: assert property (!(ctrl_started && link_out) |=> !lamp_out_green)
    else $error("out lamp lit without link");
  AST_IN_DARK: assert property (!(ctrl_started && link_in) |=> !lamp_in_green)
    else $error("in lamp lit without link");
  AST_OUT_STEADY: assert property ((ctrl_started && link_out && !frame_out) [*8]
    |=> lamp_out_green) else $error("out lamp not steady with idle link");
  AST_NET_INIT: assert property (al_state == fsl_pkg::FSL_AL_INIT && !ldr
    |=> !lamp_net_green) else $error("net lamp lit in init");
  AST_NET_OP: assert property (!$past(srst) && al_state == fsl_pkg::FSL_AL_OP && !ldr
    |=> lamp_net_green) else $error("net lamp dark in operational");
  AST_LDR_GREEN: assert property (ldr |=> !lamp_net_green)
    else $error("net green lit while loader runs");
  AST_NET_RED: assert property (!ldr |=> !lamp_net_red)
    else $error("net red lit without loader");
  AST_ERR_OFF: assert property (!ldr && no_err && al_change != 8'h01 |=> !lamp_err_red)
    else $error("error lamp lit without error");
  AST_ERR_STEADY: assert property (!$past(srst) && !ldr && (pdi_fail || fatal_stall)
    |=> lamp_err_red) else $error("error lamp not steady on failure");
  AST_RDATA_IDLE: assert property (!(hsel && hready && htrans[1] && !hwrite)
    |=> hrdata == 32'h0) else $error("read data outside data phase");
endmodule : fsl_led_driver_sva

bind fsl_led_driver fsl_led_driver_sva chk_u (.*);

`default_nettype wire

// ===== verification/fieldbus_status_led_driver_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "fsl_regs.svh"

module fieldbus_status_led_driver_bench;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0, hwrite = 1'b0, clr = 1'b0, en = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, al_state = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  al_change = 8'h00;
  logic        ctrl_started = 1'b0, link_out = 1'b0, link_in = 1'b0;
  logic        frame_out = 1'b0, frame_in = 1'b0, cfg_error = 1'b0;
  logic        sm_wdog_timeout = 1'b0, pdi_fail = 1'b0, fatal_stall = 1'b0;
  logic        firmware_loader_protocol_run = 1'b0, firmware_loader_protocol_busy = 1'b0;
  logic        hreadyout, hresp, irq;
  logic        lamp_out_green, lamp_in_green, lamp_net_green, lamp_net_red, lamp_err_red;
  wire logic   hready = hreadyout;
  wire logic [4:0] lamps = {lamp_err_red, lamp_net_red, lamp_net_green, lamp_in_green,
                            lamp_out_green};
  logic [7:0]  ons [5];
  logic [7:0]  edges [5];
  int          n_fail = 0;
  int          comparisons = 0;

  fsl_led_driver #(.UNIT_CYC(8), .LDR_IDLE_CYC(30), .LDR_BUSY_CYC(5), .FLICKER_CYC(2))
    dut_u (.*);
  fsl_lamp_mon mon_u (.clk(clk), .clr(clr), .en(en), .lamps(lamps), .ons(ons), .edges(edges));

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : ahb

  // lamp statistics over n cycles once the inputs have settled
  task automatic measure(input int n);
    tick(3);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    en <= 1'b1;
    tick(n);
    en <= 1'b0;
    tick(1);
  endtask : measure

  task automatic pat(input int i, input int on, input int ed);
    chk({24'h0, ons[i]}, on);
    chk({24'h0, edges[i]}, ed);
  endtask : pat

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({27'h0, lamps}, 32'h0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    chk(32'(irq), 32'h0);
    ahb(1'b0, `FSL_ADDR_IRQ_MASK, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, 32'hfc, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_link();
    ctrl_started <= 1'b1;
    measure(48);
    pat(0, 0, 0);
    link_out <= 1'b1;
    link_in <= 1'b1;
    measure(48);
    pat(0, 48, 0);
    pat(1, 48, 0);
    frame_out <= 1'b1;
    frame_in <= 1'b1;
    measure(48);
    pat(0, 24, 24);
    pat(1, 24, 24);
    frame_out <= 1'b0;
    frame_in <= 1'b0;
    ctrl_started <= 1'b0;
    measure(48);
    pat(0, 0, 0);
    pat(1, 0, 0);
    $display("test link done");
  endtask : t_link

  task automatic t_net();
    int ex_on [4] = '{0, 96, 32, 192};
    int ex_ed [4] = '{0, 24, 8, 0};
    for (int s = 0; s < 4; s++) begin
      al_state <= 2'(s);
      measure(192);
      pat(2, ex_on[s], ex_ed[s]);
      pat(3, 0, 0);
    end
    ahb(1'b0, `FSL_ADDR_LAMP, 32'h0);
    chk(rd, 32'h0000_0304);
    $display("test network done");
  endtask : t_net

  task automatic err_step(input logic [4:0] src, input int on, input int ed);
    {cfg_error, sm_wdog_timeout, pdi_fail, fatal_stall} <= src[4:1];
    al_change <= {7'h0, src[0]};
    measure(192);
    pat(4, on, ed);
  endtask : err_step

  task automatic t_err();
    err_step(5'b10000, 96, 24);
    err_step(5'b10001, 32, 8);
    err_step(5'b11001, 48, 12);
    err_step(5'b11101, 192, 0);
    err_step(5'b00010, 192, 0);
    err_step(5'b00000, 0, 0);
    $display("test error done");
  endtask : t_err

  task automatic t_ldr();
    firmware_loader_protocol_run <= 1'b1;
    measure(120);
    pat(3, 60, 4);
    pat(4, 60, 4);
    pat(2, 0, 0);
    firmware_loader_protocol_busy <= 1'b1;
    measure(120);
    pat(3, 60, 24);
    pat(4, 60, 24);
    firmware_loader_protocol_run <= 1'b0;
    firmware_loader_protocol_busy <= 1'b0;
    tick(2);
    $display("test loader done");
  endtask : t_ldr

  task automatic t_irq();
    ahb(1'b1, `FSL_ADDR_IRQ_MASK, 32'h1 << `FSL_IRQ_CFG);
    ahb(1'b0, `FSL_ADDR_IRQ_MASK, 32'h0);
    chk(rd, 32'h1 << `FSL_IRQ_CFG);
    // byte-sized write must leave the mask alone
    hsize <= 3'h0;
    ahb(1'b1, `FSL_ADDR_IRQ_MASK, 32'h3f);
    hsize <= 3'h2;
    ahb(1'b0, `FSL_ADDR_IRQ_MASK, 32'h0);
    chk(rd, 32'h1 << `FSL_IRQ_CFG);
    // every event kind has happened at least once since reset
    ahb(1'b0, `FSL_ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h3f);
    tick(2);
    chk(32'(irq), 32'h0);
    cfg_error <= 1'b1;
    tick(3);
    chk(32'(irq), 32'h1);
    ahb(1'b0, `FSL_ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h1 << `FSL_IRQ_CFG);
    tick(2);
    chk(32'(irq), 32'h0);
    ahb(1'b1, `FSL_ADDR_IRQ_MASK, 32'h0);
    cfg_error <= 1'b0;
    tick(2);
    cfg_error <= 1'b1;
    tick(3);
    chk(32'(irq), 32'h0);
    ahb(1'b0, `FSL_ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h1 << `FSL_IRQ_CFG);
    cfg_error <= 1'b0;
    $display("test interrupt done");
  endtask : t_irq

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(6);
    srst <= 1'b0;
    tick(2);
    t_reset();
    t_link();
    t_net();
    t_err();
    t_ldr();
    t_irq();
    conclude();
  end

  initial begin
    #400000;
    n_fail++;
    conclude();
  end
endmodule : fieldbus_status_led_driver_bench

`default_nettype wire
